// ### core/rbg_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module rbg_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
            $error("rbg_fifo depth must be a power of two, at least 2");
        end
    end

    typedef struct packed {
        logic [AW:0] wr_ptr;
        logic [AW:0] rd_ptr;
    } rbg_fifo_st_t;

    rbg_fifo_st_t st_reg, st_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push, pop;
    logic full, empty;

    assign full = (st_reg.wr_ptr[AW] != st_reg.rd_ptr[AW]) &&
                  (st_reg.wr_ptr[AW-1:0] == st_reg.rd_ptr[AW-1:0]);
    assign empty = st_reg.wr_ptr == st_reg.rd_ptr;
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[st_reg.rd_ptr[AW-1:0]];
    assign push = in_valid && !full;
    assign pop = out_ready && !empty;

    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
        end
        if (pop) begin
            st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[st_reg.wr_ptr[AW-1:0]] <= in_data;
        end
    end
endmodule
`default_nettype wire

// ### core/rbg_guard.sv
// Receive frame buffer guard and programmable start-of-frame delimiter
//
// Contract
// - In listen states frames keep arriving; unguarded, each replaces the previous one.
// - Guard holds off further radio frames until buffer read ends with select high.
// - Basic mode protects a frame only when its check sequence is valid.
// - Extended mode protects a frame when its frame end event fires.
// - Guard works only with lock enable bit 7 at 0x0C, in listen states.
// - Only radio writes are blocked; host buffer writes still land.
// - Release on select rising after buffer read, or on leaving listen states.
// - Guard ignores the detect threshold level setting entirely.
// - Delimiter is one octet for byte alignment, never stored in buffer.
// - Transmit sends delimiter octet LSB first right after the last preamble bit.
// - Delimiter register at 0x0B is read/write, resets to 0xA7, used both ways.
// - Frame start event only on delimiter match followed by a valid PHY header.
// - Control 0x0C bits 6,4,3 read zero; bit 5 resets one; bits 2..0 writable.
`timescale 1ns/10ps
`default_nettype none
module rbg_guard
    import rbg_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Host register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Host frame buffer access and chip select pin
    input wire logic host_sel_n,
    input wire logic host_buf_read,
    input wire logic host_buf_wr,
    input wire logic [6:0] host_buf_addr,
    input wire logic [7:0] host_buf_wdata,
    // Transceiver state and mode
    input wire rbg_pkg::rbg_trx_state_t trx_state,
    input wire logic extended_mode,
    // Radio receive octet stream and frame status
    input wire logic rx_octet_valid,
    input wire logic [7:0] rx_octet,
    input wire logic rx_sync,
    input wire logic rx_fcs_valid,
    input wire logic rx_frame_end,
    // Radio transmit bit stream
    input wire logic tx_preamble_done,
    input wire logic tx_bit_take,
    output logic tx_bit,
    output logic tx_bit_valid,
    // Frame buffer write port
    output logic buf_we,
    output logic [6:0] buf_waddr,
    output logic [7:0] buf_wdata,
    // Status and configuration outputs
    output logic frame_start_event,
    output logic frame_end_event,
    output logic buffer_locked,
    output logic chip_scrambler_enable,
    output logic [2:0] phy_rate_select,
    output logic rx_overrun
);
    import rbg_pkg::*;

    initial begin
        if (FIFO_DEPTH < 2) begin
            $error("rbg_guard FIFO depth must be at least 2");
        end
    end

    // ------------------------------------------------------------
    // State record
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] delimiter_octet;
        logic [7:0] ctrl2;
        logic [2:0] sel_pipe;
        logic sel_level;
        logic read_seen;
        logic locked;
        rbg_trx_state_t state_prev;
        rbg_rx_phase_t rx_phase;
        logic [6:0] rx_len;
        logic [6:0] rx_idx;
        logic frame_blocked;
        rbg_tx_phase_t tx_phase;
        logic [7:0] tx_shift;
        logic [2:0] tx_cnt;
        logic tx_bit;
        logic tx_bit_valid;
        logic [7:0] rdata;
        logic buf_we;
        logic [6:0] buf_waddr;
        logic [7:0] buf_wdata;
        logic start_ev;
        logic end_ev;
        logic overrun;
    } rbg_st_t;

    rbg_st_t st_reg, st_next;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic in_listen(input rbg_trx_state_t s);
        in_listen = (s == RBG_ST_LISTEN) || (s == RBG_ST_AACK_LISTEN);
    endfunction

    function automatic logic [7:0] reg_read(input logic [5:0] a, input rbg_st_t s);
        case (a)
            RBG_ADDR_DELIM: reg_read = s.delimiter_octet;
            RBG_ADDR_CTRL2: reg_read = s.ctrl2 & RBG_CTRL2_WMASK;
            default: reg_read = 8'h00;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Received octet FIFO (data path to frame buffer)
    // ------------------------------------------------------------
    logic fifo_in_valid, fifo_in_ready;
    logic fifo_out_valid, fifo_out_ready;
    logic [7:0] fifo_out_data;
    logic host_has_buf;

    // Only body octets enter the buffer path; the delimiter never does
    assign fifo_in_valid = rx_octet_valid && (st_reg.rx_phase == RBG_RX_BODY);
    assign host_has_buf = host_buf_wr;
    // Host writes take the buffer port first, radio octets wait
    assign fifo_out_ready = !host_has_buf;

    rbg_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .nrst(nrst),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(rx_octet),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic sel_rise;
    logic fifo_pop;
    logic radio_we;

    always_comb begin
        st_next = st_reg;
        st_next.start_ev = 1'b0;
        st_next.end_ev = 1'b0;
        st_next.buf_we = 1'b0;

        // Select pin through three flops; edge once last two agree
        st_next.sel_pipe = {st_reg.sel_pipe[1:0], host_sel_n};
        if (st_reg.sel_pipe[2] == st_reg.sel_pipe[1]) begin
            st_next.sel_level = st_reg.sel_pipe[2];
        end
        sel_rise = st_reg.sel_pipe[2] && st_reg.sel_pipe[1] && !st_reg.sel_level;

        // Registers
        if (reg_wr) begin
            if (reg_addr == RBG_ADDR_DELIM) begin
                st_next.delimiter_octet = reg_wdata;
            end else if (reg_addr == RBG_ADDR_CTRL2) begin
                st_next.ctrl2 = reg_wdata & RBG_CTRL2_WMASK;
            end
        end
        if (reg_rd) begin
            st_next.rdata = reg_read(reg_addr, st_reg);
        end

        // Release on select rise after a buffer read; a new set below wins
        if (sel_rise && st_reg.read_seen) begin
            st_next.locked = 1'b0;
            st_next.read_seen = 1'b0;
        end

        // Buffer read session tracking; a read in the release cycle survives
        if (host_buf_read) begin
            st_next.read_seen = 1'b1;
        end

        // Receive header decoding
        case (st_reg.rx_phase)
            RBG_RX_HUNT: begin
                if (rx_sync && rx_octet_valid && rx_octet == st_reg.delimiter_octet) begin
                    st_next.rx_phase = RBG_RX_PHR;
                end
            end
            RBG_RX_PHR: begin
                if (rx_octet_valid) begin
                    if (rx_octet[6:0] >= RBG_PHR_LEN_MIN && !rx_octet[7]) begin
                        st_next.start_ev = 1'b1;
                        st_next.rx_len = rx_octet[6:0];
                        st_next.rx_idx = 7'h00;
                        // Frame is dropped if a protected frame is held
                        st_next.frame_blocked = st_reg.locked;
                        st_next.rx_phase = RBG_RX_BODY;
                    end else begin
                        st_next.rx_phase = RBG_RX_HUNT;
                    end
                end
            end
            RBG_RX_BODY: begin
                if (rx_octet_valid && !fifo_in_ready) begin
                    st_next.overrun = 1'b1;
                end
                if (rx_frame_end) begin
                    st_next.end_ev = 1'b1;
                    st_next.rx_phase = RBG_RX_HUNT;
                    // Protection; threshold level plays no part
                    if (st_reg.ctrl2[RBG_BIT_LOCK_EN] && in_listen(trx_state) &&
                        !st_reg.frame_blocked) begin
                        if (extended_mode) begin
                            st_next.locked = 1'b1;
                        end else if (rx_fcs_valid) begin
                            st_next.locked = 1'b1;
                        end
                    end
                end
            end
            default: st_next.rx_phase = RBG_RX_HUNT;
        endcase
        if (!in_listen(trx_state)) begin
            st_next.rx_phase = RBG_RX_HUNT;
        end

        // Radio writes into frame buffer; blocked while protected
        fifo_pop = fifo_out_valid && fifo_out_ready;
        radio_we = fifo_pop && !st_reg.frame_blocked && in_listen(trx_state);
        if (host_buf_wr) begin
            st_next.buf_we = 1'b1;
            st_next.buf_waddr = host_buf_addr;
            st_next.buf_wdata = host_buf_wdata;
        end else if (radio_we) begin
            st_next.buf_we = 1'b1;
            st_next.buf_waddr = st_reg.rx_idx;
            st_next.buf_wdata = fifo_out_data;
        end
        if (fifo_pop) begin
            st_next.rx_idx = st_reg.rx_idx + 7'h01;
        end

        // Release on leaving listen states or disabling the guard
        if (in_listen(st_reg.state_prev) && !in_listen(trx_state)) begin
            st_next.locked = 1'b0;
        end
        if (!st_reg.ctrl2[RBG_BIT_LOCK_EN]) begin
            st_next.locked = 1'b0;
        end
        st_next.state_prev = trx_state;

        // Transmit delimiter, LSB first after preamble
        case (st_reg.tx_phase)
            RBG_TX_IDLE: begin
                st_next.tx_bit_valid = 1'b0;
                if (tx_preamble_done) begin
                    st_next.tx_shift = st_reg.delimiter_octet;
                    st_next.tx_cnt = 3'h0;
                    st_next.tx_bit = st_reg.delimiter_octet[0];
                    st_next.tx_bit_valid = 1'b1;
                    st_next.tx_phase = RBG_TX_DELIM;
                end
            end
            RBG_TX_DELIM: begin
                if (tx_bit_take) begin
                    if (st_reg.tx_cnt == RBG_TXBIT_LAST) begin
                        st_next.tx_bit_valid = 1'b0;
                        st_next.tx_phase = RBG_TX_IDLE;
                    end else begin
                        st_next.tx_shift = {1'b0, st_reg.tx_shift[7:1]};
                        st_next.tx_bit = st_reg.tx_shift[1];
                        st_next.tx_cnt = st_reg.tx_cnt + 3'h1;
                    end
                end
            end
            default: st_next.tx_phase = RBG_TX_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '0;
            st_reg.delimiter_octet <= RBG_DELIM_RESET;
            st_reg.ctrl2 <= RBG_CTRL2_RESET;
            st_reg.sel_pipe <= 3'h7;
            st_reg.sel_level <= 1'b1;
            st_reg.locked <= 1'b0;
            st_reg.state_prev <= RBG_ST_OTHER;
            st_reg.rx_phase <= RBG_RX_HUNT;
            st_reg.tx_phase <= RBG_TX_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata = st_reg.rdata;
    assign tx_bit = st_reg.tx_bit;
    assign tx_bit_valid = st_reg.tx_bit_valid;
    assign buf_we = st_reg.buf_we;
    assign buf_waddr = st_reg.buf_waddr;
    assign buf_wdata = st_reg.buf_wdata;
    assign frame_start_event = st_reg.start_ev;
    assign frame_end_event = st_reg.end_ev;
    assign buffer_locked = st_reg.locked;
    assign chip_scrambler_enable = st_reg.ctrl2[RBG_BIT_SCRAM];
    assign phy_rate_select = st_reg.ctrl2[RBG_RATE_LSB +: RBG_RATE_W];
    assign rx_overrun = st_reg.overrun;
endmodule
`default_nettype wire

// ### shared/rbg_pkg.sv
// Package: register map, reset values and enumerations of the receive buffer guard
package rbg_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [5:0] RBG_ADDR_DELIM = 6'h0B;
    localparam logic [5:0] RBG_ADDR_CTRL2 = 6'h0C;
    localparam logic [7:0] RBG_DELIM_RESET = 8'hA7;
    localparam logic [7:0] RBG_CTRL2_RESET = 8'h20;
    localparam logic [7:0] RBG_CTRL2_WMASK = 8'hA7;
    localparam int RBG_BIT_LOCK_EN = 7;
    localparam int RBG_BIT_SCRAM = 5;
    localparam int RBG_RATE_LSB = 0;
    localparam int RBG_RATE_W = 3;
    // ------------------------------------------------------------
    // Transceiver states and receive/transmit phases
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RBG_ST_OTHER,
        RBG_ST_LISTEN,
        RBG_ST_AACK_LISTEN
    } rbg_trx_state_t;
    typedef enum logic [1:0] {
        RBG_RX_HUNT,
        RBG_RX_PHR,
        RBG_RX_BODY
    } rbg_rx_phase_t;
    typedef enum logic [1:0] {
        RBG_TX_IDLE,
        RBG_TX_DELIM,
        RBG_TX_BODY
    } rbg_tx_phase_t;
    localparam logic [2:0] RBG_TXBIT_LAST = 3'h7;
    localparam logic [6:0] RBG_PHR_LEN_MIN = 7'h01;
endpackage

// ### verif/rbg_guard_props.sv
// Checker of the receive buffer guard top ports
`timescale 1ns/10ps
`default_nettype none
module rbg_guard_chk
    import rbg_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Host side
    input wire logic reg_wr,
    input wire logic [5:0] reg_addr,
    input wire logic host_sel_n,
    input wire logic host_buf_read,
    input wire logic host_buf_wr,
    // Radio side
    input wire rbg_pkg::rbg_trx_state_t trx_state,
    input wire logic extended_mode,
    input wire logic rx_octet_valid,
    input wire logic [7:0] rx_octet,
    input wire logic rx_fcs_valid,
    input wire logic rx_frame_end,
    input wire logic tx_preamble_done,
    // Outputs
    input wire logic tx_bit_valid,
    input wire logic buf_we,
    input wire logic frame_start_event,
    input wire logic frame_end_event,
    input wire logic buffer_locked,
    input wire logic chip_scrambler_enable
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    AST_LOCK_CAUSE: assert property ($rose(buffer_locked) |-> $past(rx_frame_end
        && trx_state != RBG_ST_OTHER && (extended_mode || rx_fcs_valid)))
        else $error("lock without a qualifying frame end");
    AST_BASIC_BAD_FCS: assert property (rx_frame_end && !extended_mode && !rx_fcs_valid
        && !buffer_locked |=> !buffer_locked) else $error("bad check sequence locked");
    AST_LEAVE_RELEASE: assert property (trx_state == RBG_ST_OTHER |=> !buffer_locked)
        else $error("lock held outside listen");
    AST_SEL_RELEASE: assert property ($rose(host_sel_n) && host_buf_read && buffer_locked
        |-> ##[1:6] !buffer_locked) else $error("select rise did not release");
    AST_RADIO_BLOCKED: assert property (buf_we && buffer_locked && $past(buffer_locked, 4)
        |-> $past(host_buf_wr) || $past(host_buf_wr, 2) || $past(host_buf_wr, 3))
        else $error("radio write while locked");
    AST_START_PHR: assert property (frame_start_event |-> $past(rx_octet_valid
        && !rx_octet[7] && rx_octet[6:0] != 7'h00)) else $error("start without header");
    AST_START_PULSE: assert property (frame_start_event |=> !frame_start_event)
        else $error("start event too long");
    AST_END_CAUSE: assert property (frame_end_event |-> $past(rx_frame_end))
        else $error("end event without frame end");
    AST_TX_START: assert property (tx_preamble_done |=> tx_bit_valid)
        else $error("delimiter not sent after preamble");
    AST_RESET_CLEAR: assert property (!$past(nrst) |-> !buffer_locked)
        else $error("lock survived reset");
    AST_CTRL_WRITE: assert property (!$stable(chip_scrambler_enable)
        |-> $past(reg_wr && reg_addr == RBG_ADDR_CTRL2)) else $error("control changed alone");
    COV_LOCK: cover property ($rose(buffer_locked));
    COV_RELEASE: cover property ($fell(buffer_locked));
    COV_START: cover property (frame_start_event);
    COV_HOST_WR_LOCKED: cover property (buf_we && buffer_locked);
endmodule
bind rbg_guard rbg_guard_chk rbg_guard_chk_i (.core_clk, .nrst, .reg_wr, .reg_addr,
    .host_sel_n, .host_buf_read, .host_buf_wr, .trx_state, .extended_mode, .rx_octet_valid,
    .rx_octet, .rx_fcs_valid, .rx_frame_end, .tx_preamble_done, .tx_bit_valid, .buf_we,
    .frame_start_event, .frame_end_event, .buffer_locked, .chip_scrambler_enable);
`default_nettype wire

// ### verif/rbg_host_model.sv
// Host microcontroller model on the register and buffer port
`timescale 1ns/10ps
`default_nettype none
module rbg_host_model (
    // Clock and read data
    input wire logic core_clk,
    input wire logic [7:0] reg_rdata,
    // Register port
    output logic reg_wr,
    output logic reg_rd,
    output logic [5:0] reg_addr,
    output logic [7:0] reg_wdata,
    // Buffer port and select
    output logic host_sel_n,
    output logic host_buf_read,
    output logic host_buf_wr,
    output logic [6:0] host_buf_addr,
    output logic [7:0] host_buf_wdata
);
    initial begin
        {reg_wr, reg_rd, host_buf_read, host_buf_wr} = 4'h0;
        reg_addr = 6'h00;
        reg_wdata = 8'h00;
        host_sel_n = 1'b1;
        host_buf_addr = 7'h00;
        host_buf_wdata = 8'h00;
    end
    // Caller keeps delimiter low nibble nonzero
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge core_clk);
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(negedge core_clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge core_clk);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask
    // One select session, optional buffer read and host write
    task automatic sess(input logic r, input logic w, input logic [7:0] d);
        @(negedge core_clk);
        host_sel_n = 1'b0;
        @(negedge core_clk);
        host_buf_read = r;
        host_buf_wr = w;
        host_buf_wdata = d;
        @(negedge core_clk);
        host_buf_wr = 1'b0;
        host_buf_wdata = ~d;
        @(negedge core_clk);
        host_sel_n = 1'b1;
        @(negedge core_clk);
        host_buf_read = 1'b0;
    endtask
endmodule
`default_nettype wire

// ### verif/tb.sv
// Self-checking testbench of the receive buffer guard
`timescale 1ns/10ps
`default_nettype none
module tb;
    import rbg_pkg::*;
    typedef struct packed {logic [5:0] a; logic [7:0] d; logic [7:0] e;} rbg_row_t;
    wire logic reg_wr, reg_rd, host_sel_n, host_buf_read, host_buf_wr;
    wire logic [5:0] reg_addr;
    wire logic [7:0] reg_wdata, host_buf_wdata;
    wire logic [6:0] host_buf_addr;
    logic core_clk = 1'b0, nrst = 1'b0, extended_mode = 1'b0, rx_octet_valid = 1'b0;
    logic rx_sync = 1'b0, rx_fcs_valid = 1'b0, rx_frame_end = 1'b0;
    logic tx_preamble_done = 1'b0, tx_bit_take = 1'b0;
    logic tx_bit, tx_bit_valid, buf_we, frame_start_event, frame_end_event;
    logic buffer_locked, chip_scrambler_enable, rx_overrun;
    logic [7:0] reg_rdata, buf_wdata, rdv, first_wd, last_wd, rx_octet = 8'h00;
    logic [6:0] buf_waddr;
    logic [2:0] phy_rate_select;
    rbg_trx_state_t trx_state = RBG_ST_LISTEN;
    int err_count = 0, samples_checked = 0, n_we = 0, n_fs = 0, n_fe = 0;
    rbg_row_t rows [5] = '{'{6'h0B, 8'h3C, 8'h3C}, '{6'h0C, 8'hFF, 8'hA7},
        '{6'h0C, 8'h58, 8'h00}, '{6'h15, 8'h5A, 8'h00}, '{6'h0C, 8'h80, 8'h80}};
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        if (buf_we === 1'b1) begin
            if (n_we == 0) first_wd = buf_wdata;
            last_wd = buf_wdata;
            n_we++;
        end
        if (frame_start_event === 1'b1) n_fs++;
        if (frame_end_event === 1'b1) n_fe++;
    end
    rbg_guard rbg_guard_i (.core_clk(core_clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .host_sel_n(host_sel_n), .host_buf_read(host_buf_read), .host_buf_wr(host_buf_wr),
        .host_buf_addr(host_buf_addr), .host_buf_wdata(host_buf_wdata), .trx_state(trx_state),
        .extended_mode(extended_mode), .rx_octet_valid(rx_octet_valid), .rx_octet(rx_octet),
        .rx_sync(rx_sync), .rx_fcs_valid(rx_fcs_valid), .rx_frame_end(rx_frame_end),
        .tx_preamble_done(tx_preamble_done), .tx_bit_take(tx_bit_take), .tx_bit(tx_bit),
        .tx_bit_valid(tx_bit_valid), .buf_we(buf_we), .buf_waddr(buf_waddr),
        .buf_wdata(buf_wdata), .frame_start_event(frame_start_event),
        .frame_end_event(frame_end_event), .buffer_locked(buffer_locked),
        .chip_scrambler_enable(chip_scrambler_enable), .phy_rate_select(phy_rate_select),
        .rx_overrun(rx_overrun));
    rbg_host_model rbg_host_model_i (.core_clk(core_clk), .reg_rdata(reg_rdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .host_sel_n(host_sel_n), .host_buf_read(host_buf_read), .host_buf_wr(host_buf_wr),
        .host_buf_addr(host_buf_addr), .host_buf_wdata(host_buf_wdata));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic end_of_test();
        if (err_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic octet(input logic [7:0] v);
        @(negedge core_clk);
        rx_sync = 1'b1;
        rx_octet_valid = 1'b1;
        rx_octet = v;
        @(negedge core_clk);
        rx_octet_valid = 1'b0;
        rx_octet = ~v;
    endtask
    task automatic frame(input logic [7:0] sd, input int n, input logic fcs);
        n_we = 0;
        n_fs = 0;
        n_fe = 0;
        octet(sd);
        octet({1'b0, 7'(n)});
        for (int i = 0; i < n; i++) octet(8'h50 + 8'(i));
        @(negedge core_clk);
        rx_fcs_valid = fcs;
        rx_frame_end = 1'b1;
        @(negedge core_clk);
        rx_frame_end = 1'b0;
        rx_fcs_valid = ~fcs;
        rx_sync = 1'b0;
        repeat (8) @(negedge core_clk);
    endtask
    initial begin
        #100000;
        err_count++;
        end_of_test();
    end
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(negedge core_clk);
        nrst = 1'b1;
        foreach (rows[i]) begin
            rbg_host_model_i.wr(rows[i].a, rows[i].d);
            rbg_host_model_i.rd(rows[i].a, rdv);
            check(rdv, rows[i].e);
            if (rows[i].a == RBG_ADDR_CTRL2)
                check({chip_scrambler_enable, phy_rate_select}, {rows[i].e[5], rows[i].e[2:0]});
        end
        rbg_host_model_i.wr(RBG_ADDR_CTRL2, 8'h00);
        frame(8'h3C, 2, 1'b1);
        check(n_we, 2);
        check(first_wd, 8'h50);
        frame(8'h3C, 3, 1'b1);
        check(n_we, 3);
        check(n_fs, 1);
        check(n_fe, 1);
        check(buf_waddr, 7'h02);
        check(buffer_locked, 0);
        frame(8'hA7, 2, 1'b1);
        check(n_fs, 0);
        check(n_we, 0);
        rbg_host_model_i.wr(RBG_ADDR_CTRL2, 8'h80);
        frame(8'h3C, 2, 1'b0);
        check(buffer_locked, 0);
        frame(8'h3C, 2, 1'b1);
        check(buffer_locked, 1);
        frame(8'h3C, 3, 1'b1);
        check(n_we, 0);
        rbg_host_model_i.sess(1'b0, 1'b1, 8'hC3);
        repeat (6) @(negedge core_clk);
        check(last_wd, 8'hC3);
        check(buffer_locked, 1);
        rbg_host_model_i.sess(1'b1, 1'b0, 8'h00);
        repeat (6) @(negedge core_clk);
        check(buffer_locked, 0);
        extended_mode = 1'b1;
        frame(8'h3C, 1, 1'b0);
        check(buffer_locked, 1);
        trx_state = RBG_ST_OTHER;
        repeat (2) @(negedge core_clk);
        check(buffer_locked, 0);
        trx_state = RBG_ST_AACK_LISTEN;
        frame(8'h3C, 1, 1'b0);
        check(buffer_locked, 1);
        check(rx_overrun, 0);
        nrst = 1'b0;
        repeat (2) @(negedge core_clk);
        nrst = 1'b1;
        check(buffer_locked, 0);
        rbg_host_model_i.rd(RBG_ADDR_DELIM, rdv);
        check(rdv, RBG_DELIM_RESET);
        rbg_host_model_i.rd(RBG_ADDR_CTRL2, rdv);
        check(rdv, 8'h20);
        tx_preamble_done = 1'b1;
        @(negedge core_clk);
        tx_preamble_done = 1'b0;
        for (int i = 0; i < 8; i++) begin
            check({tx_bit_valid, tx_bit}, {1'b1, RBG_DELIM_RESET[i]});
            tx_bit_take = 1'b1;
            @(negedge core_clk);
        end
        tx_bit_take = 1'b0;
        check(tx_bit_valid, 0);
        end_of_test();
    end
endmodule
`default_nettype wire
